// ===== adsc_consts.vh
`ifndef ADSC_CONSTS_VH
`define ADSC_CONSTS_VH
`define ADSC_ADDR_RESULT 8'h25
`define ADSC_ADDR_CTRL 8'h26
`define ADSC_ADDR_CLKSEL 8'h27
`define ADSC_CTRL_SEL_LO 0
`define ADSC_CTRL_SEL_HI 1
`define ADSC_CTRL_PCFG_LO 3
`define ADSC_CTRL_PCFG_HI 4
`define ADSC_CTRL_DONE 6
`define ADSC_CTRL_START 7
`define ADSC_CLKSEL_TEST 7
`define ADSC_CTRL_RESET 8'h40
`define ADSC_CLKSEL_RESET 8'h00
`define ADSC_CONV_PERIODS 6'd32
`define ADSC_DIV2_LAST 5'd1
`define ADSC_DIV8_LAST 5'd7
`define ADSC_DIV32_LAST 5'd31
`endif

// ===== adsc_clkdiv.v
`timescale 1ns/1ps
`default_nettype none
// Converter clock divider: one-cycle tick per converter clock period
module adsc_clkdiv (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire restart,
    input wire [1:0] sel,
    // Tick
    output reg tick
);
`include "adsc_consts.vh"
reg [4:0] count;
reg [4:0] last;

always @* begin
    case (sel)
        2'b00: last = `ADSC_DIV2_LAST;
        2'b01: last = `ADSC_DIV8_LAST;
        2'b10: last = `ADSC_DIV32_LAST;
        // Encoding 11 is undefined; run as the slowest rate
        default: last = `ADSC_DIV32_LAST;
    endcase
end

always @(posedge clk) begin
    if (!rst_n || restart) begin
        count <= 5'h00;
        tick <= 1'b0;
    end else if (count >= last) begin
        count <= 5'h00;
        tick <= 1'b1;
    end else begin
        count <= count + 5'h01;
        tick <= 1'b0;
    end
end
endmodule
`default_nettype wire

// ===== adsc_sar.v
`timescale 1ns/1ps
`default_nettype none
// Successive approximation engine: one bit per two converter periods
module adsc_sar (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire clear,
    input wire go,
    input wire tick,
    // Comparator from analog front end
    input wire comp_high,
    // Status
    output reg busy,
    output reg done,
    output reg [7:0] trial,
    output reg [7:0] result
);
`include "adsc_consts.vh"
reg [5:0] periods;
reg [7:0] bit_mask;

always @(posedge clk) begin
    if (!rst_n || clear) begin
        busy <= 1'b0;
        done <= 1'b0;
        periods <= 6'h00;
        bit_mask <= 8'h80;
        trial <= 8'h80;
        result <= 8'h00;
    end else begin
        done <= 1'b0;
        if (go && !busy) begin
            busy <= 1'b1;
            periods <= 6'h00;
            bit_mask <= 8'h80;
            trial <= 8'h80;
        end else if (busy && tick) begin
            periods <= periods + 6'h01;
            // Decide a bit on each odd period below 16, settle on even
            if (periods[0] && periods < 6'd16) begin
                bit_mask <= bit_mask >> 1;
                trial <= (comp_high ? trial : (trial & ~bit_mask))
                         | (bit_mask >> 1);
            end
            if (periods == `ADSC_CONV_PERIODS - 6'd1) begin
                busy <= 1'b0;
                done <= 1'b1;
                result <= trial;
            end
        end
    end
end
endmodule
`default_nettype wire

// ===== adsc_top.v
// Behaviour
// - Read-only 8-bit result register, bit0 LSB
// - Control bits 1:0 select analog input
// - Control bits 4:3 set analog pin count
// - Analog pin: digital I/O, pull-high off
// - Both config bits zero: converter powered off
// - Start rise resets, sets done flag; fall starts
// - Done flag cleared when conversion completes
// - Completion sets converter interrupt request flag
// - Clock select bits choose divide 2/8/32
// - Clock select bit 7 test; 2-6 read 0
// - Conversion takes 32 converter clock periods
// - Control bits 2 and 5 read zero
`timescale 1ns/1ps
`default_nettype none
module adsc_top (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data memory access
    input wire [7:0] mem_addr,
    input wire mem_wr,
    input wire mem_rd,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata,
    // Comparator output from the analog front end
    input wire comp_high,
    // Analog front end control
    output reg conv_power_on,
    output reg [1:0] conv_input_sel,
    output reg [7:0] dac_trial,
    output reg sample_hold,
    // Port pin control, one bit per pin, 1 = analog
    output reg [3:0] pin_analog,
    output reg [3:0] pin_digital_disable,
    output reg [3:0] pin_pullhigh_disable,
    // Interrupt request flag, cleared by the interrupt controller
    input wire irq_clear,
    output reg conv_irq_flag,
    // Factory test bit
    output reg test_mode
);
`include "adsc_consts.vh"

reg [1:0] input_sel;
reg [1:0] pin_cfg;
reg conversion_done_flag;
reg start_bit;
reg [1:0] conv_clock_sel;
reg test_bit;
reg [7:0] result_reg;
reg start_req;
reg conv_clear;
reg [3:0] next_pin_analog;

wire tick;
wire sar_busy;
wire sar_done;
wire [7:0] sar_trial;
wire [7:0] sar_result;
wire wr_ctrl;
wire wr_clksel;
wire new_start;

assign wr_ctrl = mem_wr && (mem_addr == `ADSC_ADDR_CTRL);
assign wr_clksel = mem_wr && (mem_addr == `ADSC_ADDR_CLKSEL);
assign new_start = mem_wdata[`ADSC_CTRL_START];

adsc_clkdiv u_div (
    .clk(clk),
    .rst_n(rst_n),
    // A falling start also restarts it, so the first period is full
    .restart(conv_clear || start_req),
    .sel(conv_clock_sel),
    .tick(tick)
);

adsc_sar u_sar (
    .clk(clk),
    .rst_n(rst_n),
    .clear(conv_clear),
    .go(start_req),
    .tick(tick),
    .comp_high(comp_high),
    .busy(sar_busy),
    .done(sar_done),
    .trial(sar_trial),
    .result(sar_result)
);

// Control and clock select registers, start edge detection
always @(posedge clk) begin
    if (!rst_n) begin
        input_sel <= 2'b00;
        pin_cfg <= 2'b00;
        start_bit <= 1'b0;
        conversion_done_flag <= 1'b1;
        conv_clock_sel <= 2'b00;
        test_bit <= 1'b0;
        start_req <= 1'b0;
        conv_clear <= 1'b0;
    end else begin
        start_req <= 1'b0;
        conv_clear <= 1'b0;
        if (wr_ctrl) begin
            input_sel <= mem_wdata[`ADSC_CTRL_SEL_HI:`ADSC_CTRL_SEL_LO];
            pin_cfg <= mem_wdata[`ADSC_CTRL_PCFG_HI:`ADSC_CTRL_PCFG_LO];
            start_bit <= new_start;
            if (new_start && !start_bit) begin
                conv_clear <= 1'b1;
            end
            if (!new_start && start_bit) begin
                start_req <= 1'b1;
            end
        end
        // A rising start beats a simultaneous completion
        if (wr_ctrl && new_start && !start_bit) begin
            conversion_done_flag <= 1'b1;
        end else if (sar_done) begin
            conversion_done_flag <= 1'b0;
        end
        if (wr_clksel) begin
            conv_clock_sel <= mem_wdata[1:0];
            test_bit <= mem_wdata[`ADSC_CLKSEL_TEST];
        end
    end
end

// Result register, loaded in the cycle the flag clears
always @(posedge clk) begin
    if (!rst_n) begin
        result_reg <= 8'h00;
    end else if (sar_done) begin
        result_reg <= sar_result;
    end
end

// Interrupt request flag: set wins over clear
always @(posedge clk) begin
    if (!rst_n) begin
        conv_irq_flag <= 1'b0;
    end else if (sar_done) begin
        conv_irq_flag <= 1'b1;
    end else if (irq_clear) begin
        conv_irq_flag <= 1'b0;
    end
end

always @* begin
    case (pin_cfg)
        2'b01: next_pin_analog = 4'b0001;
        2'b10: next_pin_analog = 4'b0011;
        2'b11: next_pin_analog = 4'b1111;
        default: next_pin_analog = 4'b0000;
    endcase
end

// Registered outputs
always @(posedge clk) begin
    if (!rst_n) begin
        pin_analog <= 4'h0;
        pin_digital_disable <= 4'h0;
        pin_pullhigh_disable <= 4'h0;
        conv_power_on <= 1'b0;
        conv_input_sel <= 2'b00;
        dac_trial <= 8'h80;
        sample_hold <= 1'b0;
        test_mode <= 1'b0;
    end else begin
        pin_analog <= next_pin_analog;
        pin_digital_disable <= next_pin_analog;
        pin_pullhigh_disable <= next_pin_analog;
        conv_power_on <= (pin_cfg != 2'b00);
        conv_input_sel <= input_sel;
        dac_trial <= sar_trial;
        sample_hold <= sar_busy;
        test_mode <= test_bit;
    end
end

// Read data; unused bits read zero
always @(posedge clk) begin
    if (!rst_n) begin
        mem_rdata <= 8'h00;
    end else if (mem_rd) begin
        case (mem_addr)
            `ADSC_ADDR_RESULT: mem_rdata <= result_reg;
            `ADSC_ADDR_CTRL: mem_rdata <= {start_bit, conversion_done_flag,
                1'b0, pin_cfg, 1'b0, input_sel};
            `ADSC_ADDR_CLKSEL: mem_rdata <= {test_bit, 5'h00,
                conv_clock_sel};
            default: mem_rdata <= 8'h00;
        endcase
    end
end
endmodule
`default_nettype wire

// ===== adsc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access
    input wire logic [7:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Converter and pins
    input wire logic conv_power_on,
    input wire logic sample_hold,
    input wire logic conv_irq_flag,
    input wire logic [3:0] pin_analog,
    input wire logic [3:0] pin_digital_disable,
    input wire logic [3:0] pin_pullhigh_disable
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire wc = mem_wr && mem_addr == 8'h26;
    wire [1:0] pc = mem_wdata[4:3];
    reg [10:0] hc;
    // Length of the current conversion
    always @(posedge clk) begin
        if (!rst_n || !sample_hold) hc <= 11'h000;
        else hc <= hc + 11'h001;
    end
    sequence s_arm;
        wc && mem_wdata[7];
    endsequence
    sequence s_fire;
        wc && !mem_wdata[7] && pc != 2'h0;
    endsequence
    property p_pwr;
        wc |-> ##2 conv_power_on == ($past(pc, 2) != 2'h0);
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power control");
    property p_pin;
        wc |-> ##2 pin_analog ==
            {{2{&$past(pc, 2)}}, $past(pc[1], 2), |$past(pc, 2)};
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin config");
    property p_dis;
        pin_digital_disable == pin_analog && pin_pullhigh_disable == pin_analog;
    endproperty
    a_dis: assert property (p_dis)
        else $error("pin disable");
    property p_rst;
        s_arm |-> ##[1:2] !sample_hold;
    endproperty
    a_rst: assert property (p_rst)
        else $error("start rise");
    property p_go;
        s_arm ##[1:20] s_fire |-> ##[1:3] sample_hold;
    endproperty
    a_go: assert property (p_go)
        else $error("start fall");
    property p_irq;
        $rose(conv_irq_flag) |-> $past(sample_hold) || $past(sample_hold, 2);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq source");
    property p_len;
        $fell(sample_hold) && !$past(wc) && !$past(wc, 2) |->
            hc > 11'h03b && hc < 11'h410;
    endproperty
    a_len: assert property (p_len)
        else $error("conversion length");
    property p_rc;
        mem_rd && mem_addr == 8'h27 |=> (mem_rdata & 8'h7c) == 8'h00;
    endproperty
    a_rc: assert property (p_rc)
        else $error("clock select read");
endmodule
`default_nettype wire

// ===== test_adsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_adsc_top;
    localparam [15:0] PM = 16'hf310;
    reg clk = 1'b0, rst_n = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
    reg irq_clear = 1'b0, comp_high = 1'b0;
    reg [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, vin = 8'h00, rd;
    wire [7:0] mem_rdata, dac_trial;
    wire [1:0] conv_input_sel;
    wire [3:0] pin_analog, pin_digital_disable, pin_pullhigh_disable;
    wire conv_power_on, sample_hold, conv_irq_flag, test_mode;
    integer errors = 0, num_checks = 0, cyc = 0, i;
    adsc_top adsc_top_inst (
        .clk(clk),
        .rst_n(rst_n),
        .mem_addr(mem_addr),
        .mem_wr(mem_wr),
        .mem_rd(mem_rd),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .comp_high(comp_high),
        .conv_power_on(conv_power_on),
        .conv_input_sel(conv_input_sel),
        .dac_trial(dac_trial),
        .sample_hold(sample_hold),
        .pin_analog(pin_analog),
        .pin_digital_disable(pin_digital_disable),
        .pin_pullhigh_disable(pin_pullhigh_disable),
        .irq_clear(irq_clear),
        .conv_irq_flag(conv_irq_flag),
        .test_mode(test_mode)
    );
    initial forever #2 clk = ~clk;
    // Ideal comparator against the test voltage
    always @(negedge clk) comp_high <= vin >= dac_trial;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            errors = errors + 1;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            mem_addr = a;
            mem_wdata = d;
            mem_wr = 1'b1;
            @(negedge clk);
            mem_wr = 1'b0;
        end
    endtask
    task rdr(input [7:0] a);
        begin
            @(negedge clk);
            mem_addr = a;
            mem_rd = 1'b1;
            @(negedge clk);
            mem_rd = 1'b0;
            @(negedge clk);
            rd = mem_rdata;
        end
    endtask
    task conv(input [1:0] d, input [7:0] v, input integer per);
        integer t0;
        begin
            vin = v;
            wr(8'h27, {6'h1f, d});
            rdr(8'h27);
            chk(rd, {6'h00, d});
            chk({7'h00, test_mode}, 8'h00);
            wr(8'h26, 8'h98);
            rdr(8'h26);
            chk(rd, 8'hd8);
            wr(8'h26, 8'h18);
            t0 = cyc;
            // Start stays low while polling the flag
            while (rd[6] && cyc < t0 + 1200) rdr(8'h26);
            chk(rd, 8'h18);
            chk({7'h00, cyc - t0 >= 32 * per && cyc - t0 <= 32 * per + 16},
                8'h01);
            chk({7'h00, conv_irq_flag}, 8'h01);
            @(negedge clk);
            irq_clear = 1'b1;
            @(negedge clk);
            irq_clear = 1'b0;
            @(negedge clk);
            chk({7'h00, conv_irq_flag}, 8'h00);
            rdr(8'h25);
            chk(rd, v);
        end
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rdr(8'h26);
        chk(rd, 8'h40);
        rdr(8'h27);
        chk(rd, 8'h00);
        wr(8'h25, 8'h5a);
        rdr(8'h25);
        chk(rd, 8'h00);
        rdr(8'h31);
        chk(rd, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(8'h26, {2'h0, 1'b1, i[3:2], 1'b1, i[1:0]});
            rdr(8'h26);
            chk(rd & 8'hbf, {3'h0, i[3:2], 1'b0, i[1:0]});
            chk({6'h00, conv_input_sel}, {6'h00, i[1:0]});
            chk({4'h0, pin_analog}, {4'h0, PM[i[3:2] * 4 +: 4]});
        end
        conv(2'h0, 8'ha5, 2);
        conv(2'h1, 8'h3c, 8);
        conv(2'h2, 8'h01, 32);
        print_verdict;
    end
endmodule
bind adsc_top adsc_chk adsc_chk_inst (
    .clk(clk),
    .rst_n(rst_n),
    .mem_addr(mem_addr),
    .mem_wr(mem_wr),
    .mem_rd(mem_rd),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .conv_power_on(conv_power_on),
    .sample_hold(sample_hold),
    .conv_irq_flag(conv_irq_flag),
    .pin_analog(pin_analog),
    .pin_digital_disable(pin_digital_disable),
    .pin_pullhigh_disable(pin_pullhigh_disable)
);
`default_nettype wire
